// ---- rtl/tdzs_top.sv ----
// transmit d/e slot source select and zero code suppression with fifo
`timescale 1ns/1ns
`include "tdzs_defs.svh"

// ----------------------------------------------------------------------
// small fifo with valid/ready on both sides
// ----------------------------------------------------------------------
module tdzs_fifo #(
  parameter int WIDTH = `TDZS_FIFO_WIDTH,
  parameter int DEPTH = `TDZS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];   // storage array
  logic [AW-1:0] wr_ptr_ff;           // next write slot
  logic [AW-1:0] rd_ptr_ff;           // oldest word
  logic [AW:0] count_ff;              // words held
  logic push;                         // word taken
  logic pop;                          // word delivered
  logic [AW-1:0] nxt_wr_ptr;
  logic [AW-1:0] nxt_rd_ptr;

  // honest full and empty
  assign wr_ready = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid = (count_ff != '0);
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem_ff[rd_ptr_ff];
  // pointers wrap at depth, not at a power of two
  assign nxt_wr_ptr = (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'h1;
  assign nxt_rd_ptr = (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'h1;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= wr_data;
    end
  end

  // pointer and occupancy bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= nxt_wr_ptr;
      end
      if (pop) begin
        rd_ptr_ff <= nxt_rd_ptr;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'h1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'h1;
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// top: per-channel transmit slot source and zero suppression
// ----------------------------------------------------------------------
module tdzs_top #(
  parameter int FIFO_DEPTH = `TDZS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // configuration levels
  input wire logic [1:0] DSLOT_SOURCE_CODE,
  input wire logic [1:0] DSLOT_LINK_SOURCE_SELECT,
  input wire logic [1:0] ZERO_SUPPRESS_TYPE,
  // incoming slot stream
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire tdzs_pkg::tdzs_slot_t IN_SLOT,
  // octets offered by the d/e sources
  input wire tdzs_pkg::tdzs_src_t SRC_OCTETS,
  // frame data link bit
  input wire logic FDL_SLOT,
  input wire logic LAPD1_FDL_BIT,
  output logic FDL_BIT,
  // outbound line octets
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [7:0] OUT_DATA
);
  import tdzs_pkg::*;

  // --------------------------------------------------------------------
  // configuration capture
  // --------------------------------------------------------------------
  logic [1:0] zs_type_ff;     // active suppression type
  logic fdl_bit_ff;           // held data link bit

  // type field loads from its level input after reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      zs_type_ff <= `TDZS_ZS_RESET;
    end else begin
      zs_type_ff <= ZERO_SUPPRESS_TYPE;
    end
  end

  // --------------------------------------------------------------------
  // d/e time slot source selection
  // --------------------------------------------------------------------
  wire [7:0] link_octet;      // octet picked by the link select field
  wire [7:0] dslot_octet;     // octet placed in a d/e slot

  // link select picks any lapd controller or the overhead port
  assign link_octet =
    (DSLOT_LINK_SOURCE_SELECT == `TDZS_LS_LAPD1) ? SRC_OCTETS.lapd1 :
    (DSLOT_LINK_SOURCE_SELECT == `TDZS_LS_LAPD2) ? SRC_OCTETS.lapd2 :
    (DSLOT_LINK_SOURCE_SELECT == `TDZS_LS_LAPD3) ? SRC_OCTETS.lapd3 :
    SRC_OCTETS.ovhd;

  // d/e code picks a controller or defers to the link select
  assign dslot_octet =
    (DSLOT_SOURCE_CODE == `TDZS_DE_LAPD1) ? SRC_OCTETS.lapd1 :
    (DSLOT_SOURCE_CODE == `TDZS_DE_LAPD2) ? SRC_OCTETS.lapd2 :
    (DSLOT_SOURCE_CODE == `TDZS_DE_LINKSEL) ? link_octet :
    SRC_OCTETS.lapd3;

  // --------------------------------------------------------------------
  // zero code suppression
  // --------------------------------------------------------------------
  wire all_zero;              // channel octet is entirely zero
  wire [7:0] stuff_octet;     // bit 8 / bit 7 stuffing result
  wire [7:0] zs_octet;        // suppressed channel octet
  wire [7:0] out_octet;       // octet pushed into the fifo

  // only channel octets of all zeros are touched
  assign all_zero = !IN_SLOT.is_dslot &&
                    (IN_SLOT.data == `TDZS_OCT_ZERO);

  // signaling frames stuff bit 7 only when the signaling bit is zero
  assign stuff_octet =
    !IN_SLOT.sig_frame ? `TDZS_OCT_BIT8 :
    !IN_SLOT.sig_bit ? `TDZS_OCT_BIT7 :
    IN_SLOT.data;

  // type field selects the replacement
  assign zs_octet =
    (zs_type_ff == `TDZS_ZS_NONE) ? IN_SLOT.data :
    (zs_type_ff == `TDZS_ZS_BIT7) ? `TDZS_OCT_BIT7 :
    (zs_type_ff == `TDZS_ZS_BIT8) ? stuff_octet :
    `TDZS_OCT_FIXED;

  // d/e slots take the selected source, channel octets pass or change
  assign out_octet = IN_SLOT.is_dslot ? dslot_octet :
                     all_zero ? zs_octet : IN_SLOT.data;

  // --------------------------------------------------------------------
  // frame data link bit, fed only by the first controller
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fdl_bit_ff <= 1'h0;
    end else if (FDL_SLOT) begin
      fdl_bit_ff <= LAPD1_FDL_BIT;
    end
  end
  assign FDL_BIT = fdl_bit_ff;

  // --------------------------------------------------------------------
  // outbound fifo; a stalled line back-pressures the slot stream
  // --------------------------------------------------------------------
  tdzs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst_n(RESET_N),
    .wr_valid(IN_VALID),
    .wr_ready(IN_READY),
    .wr_data(out_octet),
    .rd_valid(OUT_VALID),
    .rd_ready(OUT_READY),
    .rd_data(OUT_DATA)
  );

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  wire push = IN_VALID && IN_READY;  // slot accepted this cycle
  wire chan_zero = push && all_zero; // all-zero channel octet accepted

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_zs_none_pass: assert property (
    chan_zero && zs_type_ff == `TDZS_ZS_NONE |-> out_octet == 8'h00)
    else $error("type 00 altered a zero octet");
  a_zs_bit7_stuff: assert property (
    chan_zero && zs_type_ff == `TDZS_ZS_BIT7 |-> out_octet == 8'h02)
    else $error("type 01 did not stuff bit 7");
  a_zs_bit8_stuff: assert property (
    chan_zero && zs_type_ff == `TDZS_ZS_BIT8 && !IN_SLOT.sig_frame
    |-> out_octet == 8'h01)
    else $error("type 10 did not stuff bit 8");
  a_zs_sig_stuff: assert property (
    chan_zero && zs_type_ff == `TDZS_ZS_BIT8 && IN_SLOT.sig_frame
    |-> out_octet == (IN_SLOT.sig_bit ? 8'h00 : 8'h02))
    else $error("type 10 signaling stuffing wrong");
  a_zs_fixed_sub: assert property (
    chan_zero && zs_type_ff == `TDZS_ZS_FIXED |-> out_octet == 8'h98)
    else $error("type 11 did not substitute 98");
  a_zs_nonzero_keep: assert property (
    push && !IN_SLOT.is_dslot && IN_SLOT.data != 8'h00
    |-> out_octet == IN_SLOT.data)
    else $error("non-zero channel octet altered");
  a_zs_type_load: assert property (
    ##1 zs_type_ff == $past(ZERO_SUPPRESS_TYPE))
    else $error("suppression type not loaded");
  a_de_code_src: assert property (
    push && IN_SLOT.is_dslot && DSLOT_SOURCE_CODE != 2'h2
    |-> out_octet ==
    (DSLOT_SOURCE_CODE == 2'h0 ? SRC_OCTETS.lapd1 :
     DSLOT_SOURCE_CODE == 2'h1 ? SRC_OCTETS.lapd2 :
     SRC_OCTETS.lapd3))
    else $error("d/e slot from wrong controller");
  a_de_link_src: assert property (
    push && IN_SLOT.is_dslot && DSLOT_SOURCE_CODE == 2'h2
    |-> out_octet ==
    (DSLOT_LINK_SOURCE_SELECT == 2'h0 ? SRC_OCTETS.lapd1 :
     DSLOT_LINK_SOURCE_SELECT == 2'h1 ? SRC_OCTETS.lapd2 :
     DSLOT_LINK_SOURCE_SELECT == 2'h2 ? SRC_OCTETS.lapd3 :
     SRC_OCTETS.ovhd))
    else $error("deferred d/e slot ignored link select");
  a_fdl_from_lapd1: assert property (
    FDL_SLOT |=> FDL_BIT == $past(LAPD1_FDL_BIT) ##1
    ($past(FDL_SLOT) || $stable(FDL_BIT)))
    else $error("data link bit not from first controller");
  a_out_hold_stall: assert property (
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("line octet dropped under stall");
  a_fifo_first_out: assert property (
    push && !OUT_VALID |=> OUT_VALID && OUT_DATA == $past(out_octet))
    else $error("first fifo word not presented");

  c_fixed_sub: cover property (chan_zero && zs_type_ff == `TDZS_ZS_FIXED);
  c_sig_stuff: cover property (
    chan_zero && zs_type_ff == `TDZS_ZS_BIT8 && IN_SLOT.sig_frame);
  c_link_defer: cover property (
    push && IN_SLOT.is_dslot && DSLOT_SOURCE_CODE == `TDZS_DE_LINKSEL);
  c_fifo_full: cover property (IN_VALID && !IN_READY);
endmodule

// ---- rtl/tdzs_defs.svh ----
// constants for the transmit d/e slot source and zero suppression block
`ifndef TDZS_DEFS_SVH
`define TDZS_DEFS_SVH

// ----------------------------------------------------------------------
// d/e time slot source codes
// ----------------------------------------------------------------------
`define TDZS_DE_LAPD1 2'h0
`define TDZS_DE_LAPD2 2'h1
`define TDZS_DE_LINKSEL 2'h2
`define TDZS_DE_LAPD3 2'h3

// ----------------------------------------------------------------------
// data link source select codes, used when the d/e code defers to it
// ----------------------------------------------------------------------
`define TDZS_LS_LAPD1 2'h0
`define TDZS_LS_LAPD2 2'h1
`define TDZS_LS_LAPD3 2'h2
`define TDZS_LS_OVHD 2'h3

// ----------------------------------------------------------------------
// zero suppression types and reset value
// ----------------------------------------------------------------------
`define TDZS_ZS_NONE 2'h0
`define TDZS_ZS_BIT7 2'h1
`define TDZS_ZS_BIT8 2'h2
`define TDZS_ZS_FIXED 2'h3
`define TDZS_ZS_RESET 2'h0

// ----------------------------------------------------------------------
// substitute octets; bit 1 is the msb, bit 8 the lsb of the octet
// ----------------------------------------------------------------------
`define TDZS_OCT_ZERO 8'h00
`define TDZS_OCT_BIT7 8'h02
`define TDZS_OCT_BIT8 8'h01
`define TDZS_OCT_FIXED 8'h98

// ----------------------------------------------------------------------
// fifo shape
// ----------------------------------------------------------------------
`define TDZS_FIFO_DEPTH 4
`define TDZS_FIFO_WIDTH 8

`endif

// ---- rtl/tdzs_pkg.sv ----
// types shared by the transmit d/e slot source and zero suppression block
package tdzs_pkg;

  // one outbound octet slot with its framing attributes
  typedef struct packed {
    logic [7:0] data;     // channel pcm octet
    logic is_dslot;       // slot is a d/e time slot
    logic sig_frame;      // frame carries robbed-bit signaling
    logic sig_bit;        // signaling bit value for this slot
  } tdzs_slot_t;

  // octets offered by the three lapd controllers and the overhead port
  typedef struct packed {
    logic [7:0] lapd1;
    logic [7:0] lapd2;
    logic [7:0] lapd3;
    logic [7:0] ovhd;
  } tdzs_src_t;

endpackage

// ---- verif/tdzs_line_sink.sv ----
// far-end line terminal model that takes outbound octets
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// line sink: accepts octets unless told to stall, keeps them in order
// ----------------------------------------------------------------------
module tdzs_line_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // octet stream from the framer
  input wire logic valid,
  input wire logic [7:0] data,
  output logic ready,
  // stall request from the bench
  input wire logic stall
);
  logic [7:0] got[$]; // octets received, oldest first

  // ready follows the stall request, so the sink can be slow or prompt
  assign ready = !stall;

  // capture one octet on each accepted transfer
  always @(posedge clk) begin
    if (rst_n && valid && ready) begin
      got.push_back(data);
    end
  end
endmodule

// ---- verif/tdzs_top_tb.sv ----
// self-checking bench for the d/e slot source and zero suppression block
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module tdzs_top_tb;
  import tdzs_pkg::*;
  logic mclk = 0, reset_n = 0, in_valid = 0, in_ready;
  logic out_valid, out_ready, fdl_slot = 0, fdl_in = 0, fdl_bit, stall = 0;
  logic [1:0] de_code = 0, link_sel = 0, zs_type = 0;
  logic [7:0] out_data;
  tdzs_slot_t in_slot = '0;
  tdzs_src_t src = '0;
  int errors = 0, total_checks = 0;

  // free-running clock, 50 ns period
  always #25 mclk = ~mclk;

  tdzs_top #(.FIFO_DEPTH(4)) u_dut (.MCLK(mclk), .RESET_N(reset_n),
    .DSLOT_SOURCE_CODE(de_code), .DSLOT_LINK_SOURCE_SELECT(link_sel),
    .ZERO_SUPPRESS_TYPE(zs_type), .IN_VALID(in_valid), .IN_READY(in_ready),
    .IN_SLOT(in_slot), .SRC_OCTETS(src), .FDL_SLOT(fdl_slot),
    .LAPD1_FDL_BIT(fdl_in), .FDL_BIT(fdl_bit), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_DATA(out_data));

  tdzs_line_sink u_sink (.clk(mclk), .rst_n(reset_n), .valid(out_valid),
    .data(out_data), .ready(out_ready), .stall(stall));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // drop valid, set the selects, give the type flop time to follow
  task automatic cfg(input logic [1:0] c, l, z);
    @(negedge mclk);
    in_valid = 0;
    de_code = c;
    link_sel = l;
    zs_type = z;
    @(negedge mclk);
  endtask

  // offer one slot and hold it until the edge that takes it
  task automatic send(input logic [7:0] d, input logic ds, sf, sb);
    int n;
    logic ok;
    n = 0;
    @(negedge mclk);
    in_valid = 1;
    in_slot = '{data: d, is_dslot: ds, sig_frame: sf, sig_bit: sb};
    ok = in_ready;
    while (!ok && n < 50) begin
      @(negedge mclk);
      ok = in_ready;
      n++;
    end
    // a slot never taken counts as a mismatch
    if (!ok) chk({7'h00, ok}, 8'h01);
    @(posedge mclk);
  endtask

  // pop the next octet seen by the line sink, bounded wait
  task automatic take(input logic [7:0] exp);
    int n;
    n = 0;
    while (u_sink.got.size() == 0 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (u_sink.got.size() == 0) chk(8'hXX, exp);
    else chk(u_sink.got.pop_front(), exp);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // release reset with type 11 offered: the first slot still sees type 00
  task automatic t_reset;
    zs_type = 2'h3;
    in_slot = '0;
    in_valid = 1'h1;
    reset_n = 1'h1;
    @(negedge mclk);
    in_valid = 1'h0;
    take(8'h00);
  endtask

  // every suppression type on an all-zero and a non-zero octet
  task automatic t_types;
    logic [7:0] e[4];
    e = '{8'h00, 8'h02, 8'h01, 8'h98};
    for (int t = 0; t < 4; t++) begin
      cfg(2'h0, 2'h0, t[1:0]);
      send(8'h00, 1'b0, 1'b0, 1'b0);
      send(8'h40, 1'b0, 1'b0, 1'b0);
      cfg(2'h0, 2'h0, t[1:0]);
      take(e[t]);
      take(8'h40);
    end
    cfg(2'h0, 2'h0, 2'h2);
    send(8'h00, 1'b0, 1'b1, 1'b0);
    send(8'h00, 1'b0, 1'b1, 1'b1);
    cfg(2'h0, 2'h0, 2'h0);
    take(8'h02);
    take(8'h00);
  endtask

  // every d/e source code and every link select, never suppressed
  task automatic t_dslot;
    logic [7:0] ls[4];
    logic [7:0] exp;
    ls = '{8'h11, 8'h22, 8'h33, 8'h44};
    src = '{lapd1: 8'h11, lapd2: 8'h22, lapd3: 8'h33, ovhd: 8'h44};
    for (int c = 0; c < 4; c++) begin
      for (int l = 0; l < 4; l++) begin
        cfg(c[1:0], l[1:0], 2'h3);
        send(8'h00, 1'b1, 1'b0, 1'b0);
        cfg(c[1:0], l[1:0], 2'h3);
        exp = (c == 2) ? ls[l] : (c == 3) ? 8'h33 : ls[c];
        take(exp);
      end
    end
  endtask

  // fill the fifo against a stalled line, then drain in order
  task automatic t_fifo;
    cfg(2'h0, 2'h0, 2'h0);
    stall = 1;
    for (int i = 1; i <= 4; i++) send(i[7:0], 1'b0, 1'b0, 1'b0);
    @(negedge mclk);
    in_slot.data = 8'h05;
    chk({7'h00, in_ready}, 8'h00);
    @(negedge mclk);
    chk({7'h00, in_ready}, 8'h00);
    stall = 0;
    send(8'h05, 1'b0, 1'b0, 1'b0);
    cfg(2'h0, 2'h0, 2'h0);
    for (int i = 1; i <= 5; i++) take(i[7:0]);
    chk(8'(u_sink.got.size()), 8'h00);
  endtask

  // data link bit comes only from the first controller
  task automatic t_fdl;
    for (int b = 1; b >= 0; b--) begin
      @(negedge mclk);
      fdl_slot = 1;
      fdl_in = b[0];
      @(negedge mclk);
      fdl_slot = 0;
      fdl_in = !b[0];
      @(negedge mclk);
      chk({7'h00, fdl_bit}, b[7:0]);
    end
  endtask

  // ----------------------------------------------------------------------
  // verdict and run control
  // ----------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence: reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    t_reset;
    t_types;
    t_dslot;
    t_fifo;
    t_fdl;
    print_verdict;
  end

  // watchdog: far beyond the 150 or so cycles the scenarios need
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
endmodule
